/* File: logic/rtca_core.sv */
module rtca_core
  import rtca_pkg::*;
#(
  parameter int OSC_DIV = OSC_HZ
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic OSC_CLK_I,
  input wire logic REG_WE_I,
  input wire logic REG_RE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic ALARM1_MATCH_I,
  input wire logic ALARM2_MATCH_I,
  input wire logic WAVE_I,
  input wire logic OSC_FAIL_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  output logic PRIMARY_IRQ_PIN_N_O,
  output logic WAVE_OR_SECOND_IRQ_PIN_N_O,
  output logic DAY_CARRY_O,
  output logic [1:0] WAVE_RATE_O
);
  logic [7:0] seconds_count;
  logic [7:0] minutes_count;
  logic [7:0] hours_count;
  logic first_alarm_irq_enable;
  logic second_alarm_irq_enable;
  logic alarm_pin_route_select;
  logic [1:0] wave_rate;
  logic chain_halt;
  logic first_alarm_match_flag;
  logic second_alarm_match_flag;
  logic osc_stop_flag;
  logic [2:0] pin_sync;
  logic m1, m2, wave_s;
  logic fail_s;
  logic halt_osc;
  logic sec_toggle;
  logic tog_s, tog_d;
  logic sec_tick;
  logic sec_wrap, min_wrap, hr_wrap;
  logic [7:0] next_seconds, next_minutes, next_hours;
  logic [7:0] rd_mux;
  logic m1_d, m2_d;
  logic a1_rise, a2_rise;

  // match strobes, wave and fail come from other logic, resynchronised;
  // wave crosses inverted so the reset zero matches its idle-high level
  rtca_sync #(.WIDTH(3)) u_pin_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i({ALARM1_MATCH_I, ALARM2_MATCH_I, ~WAVE_I}),
    .q_o(pin_sync)
  );
  assign m1 = pin_sync[2];
  assign m2 = pin_sync[1];
  assign wave_s = ~pin_sync[0]; // no false low on the shared pin after reset

  rtca_sync #(.WIDTH(1)) u_fail_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(OSC_FAIL_I),
    .q_o(fail_s)
  );

  // halt level crosses into the oscillator domain
  rtca_sync #(.WIDTH(1)) u_halt_sync (
    .clk_i(OSC_CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(chain_halt),
    .q_o(halt_osc)
  );

  // one-second divider in the oscillator domain
  rtca_tick #(.DIV(OSC_DIV)) u_tick (
    .osc_clk_i(OSC_CLK_I),
    .rst_n_i(RST_N_I),
    .run_i(~halt_osc),
    .sec_toggle_o(sec_toggle)
  );

  // toggle crossing back to the system clock
  rtca_sync #(.WIDTH(1)) u_tog_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(sec_toggle),
    .q_o(tog_s)
  );

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tog_d <= 1'b0;
    end else begin
      tog_d <= tog_s;
    end
  end
  assign sec_tick = (tog_s ^ tog_d) & ~chain_halt;

  // bcd increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == BCD_9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcd_inc

  // next-value logic for the time chain
  always_comb begin
    sec_wrap = sec_tick && (seconds_count[6:0] == BCD_59[6:0]);
    min_wrap = sec_wrap && (minutes_count[6:0] == BCD_59[6:0]);
    hr_wrap = 1'b0;
    next_seconds = seconds_count;
    next_minutes = minutes_count;
    next_hours = hours_count;
    if (sec_tick) begin
      next_seconds = sec_wrap ? TIME_RST : bcd_inc(seconds_count);
    end
    if (sec_wrap) begin
      next_minutes = min_wrap ? TIME_RST : bcd_inc(minutes_count);
    end
    if (min_wrap) begin
      if (hours_count[HRS_FMT]) begin
        // 12-hour: 11 -> 12 flips pm, 12 -> 01
        if (hours_count[4:0] == BCD_12) begin
          next_hours = {2'b01, hours_count[HRS_PM], BCD_01};
        end else if (hours_count[4:0] == BCD_11) begin
          next_hours = {2'b01, ~hours_count[HRS_PM], BCD_12};
          hr_wrap = hours_count[HRS_PM];
        end else begin
          next_hours = {2'b01, hours_count[HRS_PM], 5'(bcd_inc({3'b000, hours_count[4:0]}))};
        end
      end else if (hours_count[5:0] == BCD_23[5:0]) begin
        next_hours = TIME_RST;
        hr_wrap = 1'b1;
      end else begin
        next_hours = {2'b00, 6'(bcd_inc({2'b00, hours_count[5:0]}))};
      end
    end
  end

  // time registers: host write wins, otherwise count
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      seconds_count <= TIME_RST;
      minutes_count <= TIME_RST;
      hours_count <= TIME_RST;
    end else begin
      seconds_count <= (REG_WE_I && REG_ADDR_I == SEC_OFS) ? (REG_WDATA_I & SEC_MASK)
                       : next_seconds;
      minutes_count <= (REG_WE_I && REG_ADDR_I == MIN_OFS) ? (REG_WDATA_I & SEC_MASK)
                       : next_minutes;
      hours_count <= (REG_WE_I && REG_ADDR_I == HRS_OFS) ? (REG_WDATA_I & SEC_MASK)
                     : next_hours;
    end
  end

  // control register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      first_alarm_irq_enable <= CTL_RST[CTL_FIRST_EN];
      second_alarm_irq_enable <= CTL_RST[CTL_SECOND_EN];
      alarm_pin_route_select <= CTL_RST[CTL_ROUTE];
      wave_rate <= CTL_RST[CTL_RS_LO +: 2];
      chain_halt <= CTL_RST[CTL_HALT];
    end else if (REG_WE_I && REG_ADDR_I == CTL_OFS) begin
      first_alarm_irq_enable <= REG_WDATA_I[CTL_FIRST_EN];
      second_alarm_irq_enable <= REG_WDATA_I[CTL_SECOND_EN];
      alarm_pin_route_select <= REG_WDATA_I[CTL_ROUTE];
      wave_rate <= REG_WDATA_I[CTL_RS_LO +: 2];
      chain_halt <= REG_WDATA_I[CTL_HALT];
    end
  end

  // rising edges of the synchronised match strobes
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      m1_d <= 1'b0;
      m2_d <= 1'b0;
    end else begin
      m1_d <= m1;
      m2_d <= m2;
    end
  end
  assign a1_rise = m1 & ~m1_d;
  assign a2_rise = m2 & ~m2_d;

  // status flags: set beats a write-zero clear
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      first_alarm_match_flag <= 1'b0;
      second_alarm_match_flag <= 1'b0;
      osc_stop_flag <= STS_RST[STS_OSF];
    end else begin
      if (a1_rise) begin
        first_alarm_match_flag <= 1'b1;
      end else if (REG_WE_I && REG_ADDR_I == STS_OFS && !REG_WDATA_I[STS_FIRST_FLAG]) begin
        first_alarm_match_flag <= 1'b0;
      end
      if (a2_rise) begin
        second_alarm_match_flag <= 1'b1;
      end else if (REG_WE_I && REG_ADDR_I == STS_OFS && !REG_WDATA_I[STS_SECOND_FLAG]) begin
        second_alarm_match_flag <= 1'b0;
      end
      if (fail_s || chain_halt) begin
        osc_stop_flag <= 1'b1;
      end else if (REG_WE_I && REG_ADDR_I == STS_OFS && !REG_WDATA_I[STS_OSF]) begin
        osc_stop_flag <= 1'b0;
      end
    end
  end

  // interrupt pin routing, active low
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRIMARY_IRQ_PIN_N_O <= 1'b1;
      WAVE_OR_SECOND_IRQ_PIN_N_O <= 1'b1;
    end else begin
      PRIMARY_IRQ_PIN_N_O <= ~((first_alarm_irq_enable & first_alarm_match_flag)
        | (~alarm_pin_route_select & second_alarm_irq_enable
           & second_alarm_match_flag));
      WAVE_OR_SECOND_IRQ_PIN_N_O <= alarm_pin_route_select
        ? ~(second_alarm_irq_enable & second_alarm_match_flag)
        : wave_s;
    end
  end

  // read mux; fixed-zero bits come back as zero
  always_comb begin
    unique case (REG_ADDR_I)
      SEC_OFS: rd_mux = seconds_count & SEC_MASK;
      MIN_OFS: rd_mux = minutes_count & SEC_MASK;
      HRS_OFS: rd_mux = hours_count & SEC_MASK;
      CTL_OFS: rd_mux = {chain_halt, 2'b00, wave_rate, alarm_pin_route_select,
                         second_alarm_irq_enable, first_alarm_irq_enable};
      STS_OFS: rd_mux = {osc_stop_flag, 5'b00000, second_alarm_match_flag,
                         first_alarm_match_flag};
      default: rd_mux = 8'h00;
    endcase
  end

  // registered outputs
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
      REG_RVALID_O <= 1'b0;
      DAY_CARRY_O <= 1'b0;
      WAVE_RATE_O <= CTL_RST[CTL_RS_LO +: 2];
    end else begin
      REG_RDATA_O <= REG_RE_I ? rd_mux : 8'h00;
      REG_RVALID_O <= REG_RE_I;
      DAY_CARRY_O <= hr_wrap;
      WAVE_RATE_O <= wave_rate;
    end
  end

  chk_a1_pin_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (first_alarm_match_flag && first_alarm_irq_enable) |=> !PRIMARY_IRQ_PIN_N_O)
    else $error("alarm 1 did not pull primary pin");
  chk_a1_masked: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!first_alarm_irq_enable && !(second_alarm_match_flag && second_alarm_irq_enable))
    |=> PRIMARY_IRQ_PIN_N_O)
    else $error("disabled alarm 1 reached primary pin");
  chk_a2_shared_pin: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (alarm_pin_route_select && second_alarm_match_flag && second_alarm_irq_enable)
    |=> !WAVE_OR_SECOND_IRQ_PIN_N_O)
    else $error("alarm 2 missed shared pin");
  chk_a2_primary_pin: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!alarm_pin_route_select && second_alarm_match_flag && second_alarm_irq_enable)
    |=> !PRIMARY_IRQ_PIN_N_O)
    else $error("alarm 2 missed primary pin");
  chk_wave_passes: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !alarm_pin_route_select |=> WAVE_OR_SECOND_IRQ_PIN_N_O == $past(wave_s))
    else $error("wave not on shared pin");
  chk_a1_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (REG_WE_I && REG_ADDR_I == STS_OFS && REG_WDATA_I[STS_FIRST_FLAG] && !a1_rise)
    |=> first_alarm_match_flag == $past(first_alarm_match_flag))
    else $error("write one changed alarm 1 flag");
  chk_a2_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (REG_WE_I && REG_ADDR_I == STS_OFS && !REG_WDATA_I[STS_SECOND_FLAG] && !a2_rise)
    |=> !second_alarm_match_flag)
    else $error("write zero kept alarm 2 flag");
  chk_sec_range: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (sec_tick && seconds_count == BCD_59 && !REG_WE_I)
    |=> seconds_count == TIME_RST && $changed(minutes_count))
    else $error("seconds wrap or carry wrong");
  chk_top_bit_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (REG_RVALID_O && $past(REG_ADDR_I) <= HRS_OFS) |-> !REG_RDATA_O[7])
    else $error("fixed zero bit read as one");
endmodule : rtca_core

/* File: inc/rtca_pkg.sv */
package rtca_pkg;
  // register offsets
  localparam logic [7:0] SEC_OFS = 8'h00;
  localparam logic [7:0] MIN_OFS = 8'h01;
  localparam logic [7:0] HRS_OFS = 8'h02;
  localparam logic [7:0] CTL_OFS = 8'h0e;
  localparam logic [7:0] STS_OFS = 8'h0f;
  // control, status and hours field positions
  localparam int CTL_FIRST_EN = 0;
  localparam int CTL_SECOND_EN = 1;
  localparam int CTL_ROUTE = 2;
  localparam int CTL_RS_LO = 3;
  localparam int CTL_HALT = 7;
  localparam int STS_FIRST_FLAG = 0;
  localparam int STS_SECOND_FLAG = 1;
  localparam int STS_OSF = 7;
  localparam int HRS_FMT = 6;
  localparam int HRS_PM = 5;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h18;
  localparam logic [7:0] STS_RST = 8'h80;
  localparam logic [7:0] TIME_RST = 8'h00;
  // valid-bit masks: fixed-zero bits read as zero
  localparam logic [7:0] SEC_MASK = 8'h7f;
  localparam logic [7:0] CTL_MASK = 8'h9f;
  localparam logic [7:0] STS_MASK = 8'h83;
  // bcd constants
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [4:0] BCD_12 = 5'h12;
  localparam logic [4:0] BCD_11 = 5'h11;
  localparam logic [4:0] BCD_01 = 5'h01;
  localparam logic [3:0] BCD_9 = 4'h9;
  // oscillator
  localparam int OSC_HZ = 32768;
endpackage : rtca_pkg

/* File: logic/rtca_sync.sv */
module rtca_sync
  import rtca_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : rtca_sync

/* File: logic/rtca_tick.sv */
module rtca_tick
  import rtca_pkg::*;
#(
  parameter int DIV = OSC_HZ
) (
  input wire logic osc_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic sec_toggle_o
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt;

  // divide the oscillator to one toggle per second while running
  always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      sec_toggle_o <= 1'b0;
    end else if (!run_i) begin
      cnt <= '0;
    end else if (cnt == CW'(DIV - 1)) begin
      cnt <= '0;
      sec_toggle_o <= ~sec_toggle_o;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule : rtca_tick

/* File: dv/rtca_far_model.sv */
module rtca_far_model
  import rtca_pkg::*;
(
  input wire logic a1_req_i,
  input wire logic a2_req_i,
  input wire logic wave_req_i,
  output logic osc_clk_o,
  output logic a1_match_o,
  output logic a2_match_o,
  output logic wave_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // free-running crystal clock, phase unrelated to the system clock
  initial begin
    osc_clk_o = 1'b0;
    a1_match_o = 1'b0;
    a2_match_o = 1'b0;
    wave_o = 1'b1;
    #5.3;
    forever #16 osc_clk_o = ~osc_clk_o;
  end
  // comparators and divider only change on the crystal clock
  always @(posedge osc_clk_o) begin
    a1_match_o <= a1_req_i;
    a2_match_o <= a2_req_i;
    wave_o <= wave_req_i;
  end
endmodule : rtca_far_model

/* File: dv/rtca_core_bench.sv */
module rtca_core_bench
  import rtca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic a1 = 1'b0;
  logic a2 = 1'b0;
  logic wave_req = 1'b1;
  logic osc, m1, m2, wave, rvalid, pri_n, sec_n, carry;
  logic [7:0] rdata;
  logic [1:0] rate;
  int bad_count = 0;
  int n_tests = 0;
  int carry_n = 0;
  rtca_far_model rtca_far_model_inst (.a1_req_i(a1), .a2_req_i(a2), .wave_req_i(wave_req),
    .osc_clk_o(osc), .a1_match_o(m1), .a2_match_o(m2), .wave_o(wave));
  rtca_core #(.OSC_DIV(4)) rtca_core_inst (.CLK_I(clk), .RST_N_I(rst_n), .OSC_CLK_I(osc),
    .REG_WE_I(we), .REG_RE_I(re), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .ALARM1_MATCH_I(m1), .ALARM2_MATCH_I(m2), .WAVE_I(wave), .OSC_FAIL_I(1'b0),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .PRIMARY_IRQ_PIN_N_O(pri_n),
    .WAVE_OR_SECOND_IRQ_PIN_N_O(sec_n), .DAY_CARRY_O(carry), .WAVE_RATE_O(rate));
  // system clock
  always #2 clk = ~clk;
  // count day carry pulses
  always @(posedge clk) begin
    if (carry === 1'b1) carry_n++;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    check({7'h0, rvalid}, 8'h01);
    d = rdata;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rdchk
  // read until the value moves away from old, bounded
  task automatic poll(input logic [7:0] a, input logic [7:0] old, output logic [7:0] d);
    d = old;
    for (int i = 0; i < 200 && d === old; i++) rd(a, d);
  endtask : poll
  // halt the chain, load a time with the format bit first, then run
  task automatic set_time(input logic [7:0] h, input logic [7:0] m, input logic [7:0] s);
    wr(CTL_OFS, 8'h98);
    wr(HRS_OFS, h);
    wr(MIN_OFS, m);
    wr(SEC_OFS, s);
    wr(CTL_OFS, 8'h18);
  endtask : set_time
  task automatic wait_carry(input int c0);
    for (int i = 0; i < 300 && carry_n == c0; i++) @(posedge clk);
  endtask : wait_carry
  // watchdog
  initial begin
    #300000;
    bad_count++;
    complete_run();
  end
  initial begin
    logic [7:0] d;
    int c0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and idle pins
    rdchk(CTL_OFS, CTL_RST);
    rdchk(STS_OFS, STS_RST);
    check({6'h0, rate}, 8'h03);
    check({6'h0, pri_n, sec_n}, 8'h03);
    // fixed-zero bits and unmapped place
    wr(CTL_OFS, 8'h98);
    wr(SEC_OFS, 8'hd9);
    rdchk(SEC_OFS, 8'h59);
    wr(HRS_OFS, 8'h95);
    rdchk(HRS_OFS, 8'h15);
    wr(8'h10, 8'h55);
    rdchk(8'h10, 8'h00);
    // bcd seconds step, valid time loaded
    set_time(8'h00, 8'h00, 8'h09);
    poll(SEC_OFS, 8'h09, d);
    check(d, 8'h10);
    // 24-hour day wrap
    c0 = carry_n;
    set_time(8'h23, 8'h59, 8'h59);
    wait_carry(c0);
    wr(CTL_OFS, 8'h98);
    check(8'(carry_n - c0), 8'h01);
    rdchk(MIN_OFS, 8'h00);
    rdchk(HRS_OFS, 8'h00);
    // halted chain must not count on
    repeat (80) @(posedge clk);
    rdchk(SEC_OFS, 8'h00);
    // 12-hour: 11 PM to 12 AM carries
    c0 = carry_n;
    set_time(8'h71, 8'h59, 8'h59);
    wait_carry(c0);
    wr(CTL_OFS, 8'h98);
    rdchk(HRS_OFS, 8'h52);
    check(8'(carry_n - c0), 8'h01);
    // 12-hour: 11 AM to 12 PM, no carry
    c0 = carry_n;
    set_time(8'h51, 8'h59, 8'h59);
    poll(HRS_OFS, 8'h51, d);
    check(d, 8'h72);
    check(8'(carry_n - c0), 8'h00);
    // wave on the shared pin with route select 0
    wr(CTL_OFS, 8'h18);
    wave_req <= 1'b0;
    repeat (20) @(posedge clk);
    check({7'h0, sec_n}, 8'h00);
    wave_req <= 1'b1;
    repeat (20) @(posedge clk);
    check({7'h0, sec_n}, 8'h01);
    // every route, alarm and enable
    for (int k = 0; k < 8; k++) begin
      wr(STS_OFS, 8'h00);
      wr(CTL_OFS, 8'h18 | {5'h0, k[2], k[1] & k[0], ~k[1] & k[0]});
      if (k[1]) a2 <= 1'b1;
      else a1 <= 1'b1;
      poll(STS_OFS, 8'h00, d);
      check(d & 8'h03, {6'h0, k[1], ~k[1]});
      check({6'h0, pri_n, sec_n}, {6'h0, ~(k[0] & ~(k[1] & k[2])), ~(k[0] & k[1] & k[2])});
      a1 <= 1'b0;
      a2 <= 1'b0;
      repeat (16) @(posedge clk);
      wr(STS_OFS, 8'h03);
      rd(STS_OFS, d);
      check(d & 8'h03, {6'h0, k[1], ~k[1]});
      wr(STS_OFS, 8'h00);
      rd(STS_OFS, d);
      check(d & 8'h03, 8'h00);
      check({6'h0, pri_n, sec_n}, 8'h03);
    end
    // rate select follows the control byte
    wr(CTL_OFS, 8'h88);
    @(posedge clk);
    #1;
    check({6'h0, rate}, 8'h01);
    complete_run();
  end
endmodule : rtca_core_bench
